// ### rtl/bhc_defines.svh
// Purpose: Constants shared by both ends of the block hash link
// Assumes: Buffer of 16-bit words, state first, block after it
// Notes:   Definitions only
`ifndef BHC_DEFINES_SVH
`define BHC_DEFINES_SVH

// ----------------------------------------
// Buffer layout
// ----------------------------------------
`define BHC_ADDR_W      6
`define BHC_HALF_W      16
`define BHC_WORD_W      32
`define BHC_ST_HALVES   16
`define BHC_BLK_BASE    16
`define BHC_BUF_DEPTH   48
`define BHC_LAST_ADDR   6'h2F
`define BHC_LAST_ST     6'h0F

// ----------------------------------------
// Algorithm and buffering
// ----------------------------------------
`define BHC_ROUNDS      64
`define BHC_LAST_ROUND  6'h3F
`define BHC_LAST_PHASE  2'h3
`define BHC_FIFO_DEPTH  16

`endif

// ### rtl/bhc_pkg.sv
// Purpose: Types shared by both ends of the block hash link
// Assumes: One-hot state codes
// Notes:   Numbers live in bhc_defines.svh
package bhc_pkg;

	typedef logic [15:0] bhc_half_t;
	typedef logic [31:0] bhc_word_t;

	typedef enum logic [8:0] {
		BHC_D_IDLE  = 9'h001,
		BHC_D_LDST  = 9'h002,
		BHC_D_LDBLK = 9'h004,
		BHC_D_DRAIN = 9'h008,
		BHC_D_ROUND = 9'h010,
		BHC_D_SUM   = 9'h020,
		BHC_D_WACK  = 9'h040,
		BHC_D_WRITE = 9'h080,
		BHC_D_DONE  = 9'h100
	} bhc_dev_state_t;

	typedef enum logic [2:0] {
		BHC_H_IDLE  = 3'h1,
		BHC_H_RUN   = 3'h2,
		BHC_H_CLOSE = 3'h4
	} bhc_host_state_t;

endpackage

// ### rtl/bhc_link_if.sv
// Purpose: Link between the hash core and its buffer owner
// Assumes: One clock, read data one cycle after the read strobe
// Notes:   No clocking block; the bench joins the two ends here
`timescale 1ns/1ps
`default_nettype none
interface bhc_link_if (
	input wire logic clk,
	input wire logic rst
);
	import bhc_pkg::*;

	logic              en;
	logic              ack;
	logic              intMode;
	logic              irq;
	logic              done;
	logic              rdStb;
	logic              wrStb;
	logic [5:0]        addr;
	bhc_half_t         wdata;
	bhc_half_t         rdata;

	modport dev (
		input  en, ack, intMode, rdata,
		output irq, done, rdStb, wrStb, addr, wdata
	);
	modport host (
		output en, ack, intMode, rdata,
		input  irq, done, rdStb, wrStb, addr, wdata
	);
endinterface
`default_nettype wire

// ### rtl/bhc_fifo.sv
// Purpose: Word FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes:   Full and empty come from an occupancy count
`timescale 1ns/1ps
`default_nettype none
module bhc_fifo #(
	parameter int W = 32,
	parameter int D = 16
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	output logic              outValid,
	input  wire logic         outReady,
	output logic [W-1:0]      outData
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [0:D-1];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0]   count;
	logic          push;
	logic          pop;

	assign inReady  = (count != D[AW:0]);
	assign outValid = (count != '0);
	assign outData  = mem[rdPtr];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= rdPtr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/bhc_core.sv
// Purpose: Single-block hash compression core, device end of the link
// Assumes: Host lays out state then block, high half first
// Notes:   One round every four cycles, schedule built alongside
`timescale 1ns/1ps
`include "bhc_defines.svh"
`default_nettype none
module bhc_core
	import bhc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	bhc_link_if.dev   bus
);
	localparam bhc_word_t K [0:63] = '{
		32'h428A2F98, 32'h71374491, 32'hB5C0FBCF, 32'hE9B5DBA5,
		32'h3956C25B, 32'h59F111F1, 32'h923F82A4, 32'hAB1C5ED5,
		32'hD807AA98, 32'h12835B01, 32'h243185BE, 32'h550C7DC3,
		32'h72BE5D74, 32'h80DEB1FE, 32'h9BDC06A7, 32'hC19BF174,
		32'hE49B69C1, 32'hEFBE4786, 32'h0FC19DC6, 32'h240CA1CC,
		32'h2DE92C6F, 32'h4A7484AA, 32'h5CB0A9DC, 32'h76F988DA,
		32'h983E5152, 32'hA831C66D, 32'hB00327C8, 32'hBF597FC7,
		32'hC6E00BF3, 32'hD5A79147, 32'h06CA6351, 32'h14292967,
		32'h27B70A85, 32'h2E1B2138, 32'h4D2C6DFC, 32'h53380D13,
		32'h650A7354, 32'h766A0ABB, 32'h81C2C92E, 32'h92722C85,
		32'hA2BFE8A1, 32'hA81A664B, 32'hC24B8B70, 32'hC76C51A3,
		32'hD192E819, 32'hD6990624, 32'hF40E3585, 32'h106AA070,
		32'h19A4C116, 32'h1E376C08, 32'h2748774C, 32'h34B0BCB5,
		32'h391C0CB3, 32'h4ED8AA4A, 32'h5B9CCA4F, 32'h682E6FF3,
		32'h748F82EE, 32'h78A5636F, 32'h84C87814, 32'h8CC70208,
		32'h90BEFFFA, 32'hA4506CEB, 32'hBEF9A3F7, 32'hC67178F2
	};

	function automatic bhc_word_t rotr(bhc_word_t x, int n);
		rotr = (x >> n) | (x << (32 - n));
	endfunction

	// ----------------------------------------
	// Control and counters
	// ----------------------------------------
	bhc_dev_state_t st;
	logic [5:0]     rdIdx;
	logic           issuedAll;
	logic           issue;
	logic           gotV;
	logic [5:0]     gotIdx;
	logic [3:0]     popCnt;
	logic [5:0]     round;
	logic [1:0]     phase;
	logic [3:0]     wrIdx;

	bhc_word_t initSt [0:7];
	bhc_word_t wk     [0:7];
	bhc_word_t outSt  [0:7];
	bhc_word_t w      [0:15];
	bhc_half_t hiHalf;

	logic      fInValid;
	logic      fInReady;
	logic      fOutValid;
	logic      fOutReady;
	bhc_word_t fOutData;

	// Stall reads when the FIFO cannot take more
	assign issue = (st == BHC_D_LDST || st == BHC_D_LDBLK)
		&& !issuedAll && fInReady;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= BHC_D_IDLE;
		end else begin
			case (st)
			BHC_D_IDLE: if (bus.en && !bus.ack) begin
				st <= BHC_D_LDST;
			end
			BHC_D_LDST: if (issue && rdIdx == `BHC_LAST_ST) begin
				st <= BHC_D_LDBLK;
			end
			BHC_D_LDBLK: if (gotV && gotIdx == `BHC_LAST_ADDR) begin
				st <= BHC_D_DRAIN;
			end
			BHC_D_DRAIN: if (fOutValid && popCnt == 4'hF) begin
				st <= BHC_D_ROUND;
			end
			BHC_D_ROUND: begin
				if (phase == `BHC_LAST_PHASE
					&& round == `BHC_LAST_ROUND) begin
					st <= BHC_D_SUM;
				end
			end
			BHC_D_SUM: st <= bus.intMode ? BHC_D_WACK : BHC_D_WRITE;
			BHC_D_WACK: if (bus.en && bus.ack) begin
				st <= BHC_D_WRITE;
			end
			BHC_D_WRITE: if (wrIdx == 4'hF) begin
				st <= BHC_D_DONE;
			end
			BHC_D_DONE: if (!bus.en) begin
				st <= BHC_D_IDLE;
			end
			default: st <= BHC_D_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdIdx     <= '0;
			issuedAll <= 1'b0;
			popCnt    <= '0;
			wrIdx     <= '0;
		end else begin
			if (st == BHC_D_IDLE) begin
				rdIdx     <= '0;
				issuedAll <= 1'b0;
				popCnt    <= '0;
				wrIdx     <= '0;
			end
			if (issue) begin
				rdIdx <= rdIdx + 6'h01;
				if (rdIdx == `BHC_LAST_ADDR) begin
					issuedAll <= 1'b1;
				end
			end
			if (st == BHC_D_DRAIN && fOutValid) begin
				popCnt <= popCnt + 4'h1;
			end
			if (st == BHC_D_WRITE) begin
				wrIdx <= wrIdx + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// Buffer strobes, all registered
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus.rdStb <= 1'b0;
			bus.wrStb <= 1'b0;
			bus.addr  <= '0;
			bus.wdata <= '0;
			bus.irq   <= 1'b0;
			bus.done  <= 1'b0;
			gotV      <= 1'b0;
			gotIdx    <= '0;
		end else begin
			bus.rdStb <= issue;
			bus.wrStb <= (st == BHC_D_WRITE);
			bus.addr  <= (st == BHC_D_WRITE) ? {2'b00, wrIdx} : rdIdx;
			// High half at the even address
			bus.wdata <= wrIdx[0] ? outSt[wrIdx[3:1]][15:0]
				: outSt[wrIdx[3:1]][31:16];
			bus.irq   <= (st == BHC_D_WACK) && !bus.ack;
			bus.done  <= (st == BHC_D_DONE);
			gotV      <= bus.rdStb;
			gotIdx    <= bus.addr;
		end
	end

	// ----------------------------------------
	// Intake: state registers and block FIFO
	// ----------------------------------------
	assign fInValid  = gotV && gotIdx >= 6'(`BHC_BLK_BASE) && gotIdx[0];
	assign fOutReady = (st == BHC_D_DRAIN);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hiHalf <= '0;
			for (int i = 0; i < 8; i++) begin
				initSt[i] <= '0;
			end
		end else if (gotV) begin
			if (gotIdx < 6'(`BHC_ST_HALVES)) begin
				if (gotIdx[0]) begin
					initSt[gotIdx[3:1]][15:0] <= bus.rdata;
				end else begin
					initSt[gotIdx[3:1]][31:16] <= bus.rdata;
				end
			end else if (!gotIdx[0]) begin
				hiHalf <= bus.rdata;
			end
		end
	end

	bhc_fifo #(
		.W(`BHC_WORD_W),
		.D(`BHC_FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.inValid  (fInValid),
		.inReady  (fInReady),
		.inData   ({hiHalf, bus.rdata}),
		.outValid (fOutValid),
		.outReady (fOutReady),
		.outData  (fOutData)
	);

	// ----------------------------------------
	// Schedule: four stages per round slot
	// ----------------------------------------
	bhc_word_t sg0;
	bhc_word_t sg1;
	bhc_word_t psum;
	bhc_word_t newW;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sg0  <= '0;
			sg1  <= '0;
			psum <= '0;
			newW <= '0;
			for (int i = 0; i < 16; i++) begin
				w[i] <= '0;
			end
		end else if (st == BHC_D_DRAIN && fOutValid) begin
			for (int i = 0; i < 15; i++) begin
				w[i] <= w[i + 1];
			end
			w[15] <= fOutData;
		end else if (st == BHC_D_ROUND) begin
			// Window slides once per round, new word at the tail
			case (phase)
			2'h0: begin
				sg0 <= rotr(w[1], 7) ^ rotr(w[1], 18) ^ (w[1] >> 3);
				sg1 <= rotr(w[14], 17) ^ rotr(w[14], 19)
					^ (w[14] >> 10);
			end
			2'h1: psum <= sg0 + sg1 + w[9];
			2'h2: newW <= psum + w[0];
			default: begin
				for (int i = 0; i < 15; i++) begin
					w[i] <= w[i + 1];
				end
				w[15] <= newW;
			end
			endcase
		end
	end

	// ----------------------------------------
	// Compression: four stages per round
	// ----------------------------------------
	bhc_word_t kw;
	bhc_word_t t1;
	bhc_word_t t2;
	bhc_word_t nA;
	bhc_word_t nE;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= '0;
			round <= '0;
			kw    <= '0;
			t1    <= '0;
			t2    <= '0;
			nA    <= '0;
			nE    <= '0;
			for (int i = 0; i < 8; i++) begin
				wk[i]    <= '0;
				outSt[i] <= '0;
			end
		end else begin
			case (st)
			BHC_D_DRAIN: begin
				phase <= '0;
				round <= '0;
				for (int i = 0; i < 8; i++) begin
					wk[i] <= initSt[i];
				end
			end
			BHC_D_ROUND: begin
				phase <= phase + 2'h1;
				case (phase)
				2'h0: kw <= K[round] + w[0];
				2'h1: begin
					t1 <= wk[7] + (rotr(wk[4], 6) ^ rotr(wk[4], 11)
						^ rotr(wk[4], 25))
						+ ((wk[4] & wk[5]) ^ (~wk[4] & wk[6])) + kw;
					t2 <= (rotr(wk[0], 2) ^ rotr(wk[0], 13)
						^ rotr(wk[0], 22)) + ((wk[0] & wk[1])
						^ (wk[0] & wk[2]) ^ (wk[1] & wk[2]));
				end
				2'h2: begin
					nA <= t1 + t2;
					nE <= wk[3] + t1;
				end
				default: begin
					round <= round + 6'h01;
					wk[0] <= nA;
					wk[1] <= wk[0];
					wk[2] <= wk[1];
					wk[3] <= wk[2];
					wk[4] <= nE;
					wk[5] <= wk[4];
					wk[6] <= wk[5];
					wk[7] <= wk[6];
				end
				endcase
			end
			BHC_D_SUM: begin
				for (int i = 0; i < 8; i++) begin
					outSt[i] <= initSt[i] + wk[i];
				end
			end
			default: begin
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ### rtl/bhc_host.sv
// Purpose: Buffer owner and transaction driver, far end of the link
// Assumes: User loads state and padded block before start
// Notes:   Digest is the first 16 buffer words after the run
`timescale 1ns/1ps
`include "bhc_defines.svh"
`default_nettype none
module bhc_host
	import bhc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        loadEn,
	input  wire logic [5:0]  loadAddr,
	input  wire logic [15:0] loadData,
	input  wire logic        start,
	input  wire logic        intMode,
	output logic             busy,
	output logic [255:0]     digest,
	output logic             digestValid,
	bhc_link_if.host         bus
);
	bhc_host_state_t st;
	bhc_half_t       mem [0:`BHC_BUF_DEPTH-1];

	assign busy = (st != BHC_H_IDLE);

	// ----------------------------------------
	// Shared buffer
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus.rdata <= '0;
			for (int i = 0; i < `BHC_BUF_DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else begin
			// Loads are only taken between blocks
			if (loadEn && !busy && loadAddr < 6'(`BHC_BUF_DEPTH)) begin
				mem[loadAddr] <= loadData;
			end else if (bus.wrStb) begin
				mem[bus.addr] <= bus.wdata;
			end
			if (bus.rdStb) begin
				bus.rdata <= mem[bus.addr];
			end
		end
	end

	// ----------------------------------------
	// Transaction sequencing
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st          <= BHC_H_IDLE;
			bus.en      <= 1'b0;
			bus.ack     <= 1'b0;
			bus.intMode <= 1'b0;
			digest      <= '0;
			digestValid <= 1'b0;
		end else begin
			digestValid <= 1'b0;
			case (st)
			BHC_H_IDLE: if (start) begin
				st          <= BHC_H_RUN;
				bus.en      <= 1'b1;
				bus.intMode <= intMode;
			end
			BHC_H_RUN: begin
				if (bus.irq) begin
					bus.ack <= 1'b1;
				end
				if (bus.done) begin
					for (int i = 0; i < 16; i++) begin
						digest[255 - 16*i -: 16] <= mem[i];
					end
					st      <= BHC_H_CLOSE;
					bus.en  <= 1'b0;
					bus.ack <= 1'b0;
				end
			end
			BHC_H_CLOSE: if (!bus.done) begin
				st          <= BHC_H_IDLE;
				digestValid <= 1'b1;
			end
			default: st <= BHC_H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### verif/bhc_link_assertions.sv
// Purpose: Protocol checks on the hash core link
// Assumes: One clock domain, reset active high
// Notes:   Instantiated beside the link interface, no bind
`timescale 1ns/1ps
`default_nettype none
module bhc_link_assertions
	import bhc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       en,
	input wire logic       ack,
	input wire logic       intMode,
	input wire logic       irq,
	input wire logic       done,
	input wire logic       rdStb,
	input wire logic       wrStb,
	input wire logic [5:0] addr,
	input wire bhc_half_t  wdata,
	input wire bhc_half_t  rdata
);
	logic [9:0] gapCnt;

	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// Saturates so a stuck core cannot wrap into the legal window
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			gapCnt <= 10'h000;
		else if (rdStb && addr == 6'h2F)
			gapCnt <= 10'h000;
		else if (gapCnt != 10'h3FF)
			gapCnt <= gapCnt + 10'h001;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_wake_read;
		$rose(en) && !ack |-> ##[1:3] rdStb && addr == 6'h00;
	endproperty
	a_wake_read: assert property (p_wake_read)
		else $error("no state read after enable");

	property p_read_seq;
		rdStb && addr != 6'h2F |=> rdStb && addr == $past(addr) + 6'h01;
	endproperty
	a_read_seq: assert property (p_read_seq)
		else $error("buffer reads not consecutive");

	property p_read_range;
		rdStb |-> addr <= 6'h2F && en;
	endproperty
	a_read_range: assert property (p_read_range)
		else $error("read outside buffer or transaction");

	property p_round_time;
		$rose(wrStb) || $rose(irq) |-> gapCnt >= 10'h100 && gapCnt <= 10'h1F4;
	endproperty
	a_round_time: assert property (p_round_time)
		else $error("result too early or too late");

	property p_irq_mode;
		irq |-> intMode;
	endproperty
	a_irq_mode: assert property (p_irq_mode)
		else $error("request raised in polling mode");

	property p_ack_write;
		$rose(ack) && en |-> ##[1:2] wrStb && addr == 6'h00;
	endproperty
	a_ack_write: assert property (p_ack_write)
		else $error("write back did not follow acknowledge");

	property p_write_seq;
		wrStb && addr != 6'h0F |=> wrStb && addr == $past(addr) + 6'h01;
	endproperty
	a_write_seq: assert property (p_write_seq)
		else $error("result writes not consecutive");

	property p_write_range;
		wrStb |-> addr <= 6'h0F;
	endproperty
	a_write_range: assert property (p_write_range)
		else $error("write outside state area");

	property p_done_after;
		wrStb && addr == 6'h0F |-> ##[1:2] done;
	endproperty
	a_done_after: assert property (p_done_after)
		else $error("done missing after last write");

	property p_done_hold;
		done && en |=> done;
	endproperty
	a_done_hold: assert property (p_done_hold)
		else $error("done dropped while enabled");

	c_poll_done: cover property (done && !intMode);
	c_int_ack: cover property (irq ##1 ack);
	c_full_read: cover property (rdStb && addr == 6'h2F);
	c_write_data: cover property (wrStb && wdata != 16'h0000);
	c_read_data: cover property ($past(rdStb) && rdata != 16'h0000);
endmodule
`default_nettype wire

// ### verif/block_hash_core_tb.sv
// Purpose: Self-checking bench joining host and core ends
// Assumes: Standard hash vectors, high half at even address
// Notes:   Wire order and counts checked by a bus monitor
`timescale 1ns/1ps
`default_nettype none
module block_hash_core_tb
	import bhc_pkg::*;
;
	localparam logic [255:0] ivStd = {128'h6A09E667_BB67AE85_3C6EF372_A54FF53A,
		128'h510E527F_9B05688C_1F83D9AB_5BE0CD19};
	localparam logic [511:0] blkAbc = {32'h61626380, 448'h0, 32'h00000018};
	localparam logic [255:0] digAbc = {128'hBA7816BF_8F01CFEA_414140DE_5DAE2223,
		128'hB00361A3_96177A9C_B410FF61_F20015AD};
	localparam logic [511:0] blkOne = {128'h61626364_62636465_63646566_64656667,
		128'h65666768_66676869_6768696A_68696A6B,
		128'h696A6B6C_6A6B6C6D_6B6C6D6E_6C6D6E6F,
		128'h6D6E6F70_6E6F7071_80000000_00000000};
	localparam logic [511:0] blkTwo = {480'h0, 32'h000001C0};
	localparam logic [255:0] digTwo = {128'h248D6A61_D20638B8_E5C02693_0C3E6039,
		128'hA33CE459_64FF2167_F6ECEDD4_19DB06C1};

	logic         clk;
	logic         rst;
	logic         loadEn;
	logic [5:0]   loadAddr;
	logic [15:0]  loadData;
	logic         start;
	logic         intMode;
	logic         busy;
	logic [255:0] digest;
	logic         digestValid;
	logic [255:0] wrImage;
	int           mismatches;
	int           nCompared;
	int           rdCnt;
	int           wrCnt;

	bhc_link_if u_bhc_link_if (.clk(clk), .rst(rst));
	bhc_core u_bhc_core (.clk(clk), .rst(rst), .bus(u_bhc_link_if));
	bhc_host u_bhc_host (
		.clk        (clk),
		.rst        (rst),
		.loadEn     (loadEn),
		.loadAddr   (loadAddr),
		.loadData   (loadData),
		.start      (start),
		.intMode    (intMode),
		.busy       (busy),
		.digest     (digest),
		.digestValid(digestValid),
		.bus        (u_bhc_link_if)
	);
	bhc_link_assertions u_bhc_link_assertions (
		.clk    (clk),
		.rst    (rst),
		.en     (u_bhc_link_if.en),
		.ack    (u_bhc_link_if.ack),
		.intMode(u_bhc_link_if.intMode),
		.irq    (u_bhc_link_if.irq),
		.done   (u_bhc_link_if.done),
		.rdStb  (u_bhc_link_if.rdStb),
		.wrStb  (u_bhc_link_if.wrStb),
		.addr   (u_bhc_link_if.addr),
		.wdata  (u_bhc_link_if.wdata),
		.rdata  (u_bhc_link_if.rdata)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ----------------------------------------
	// Compare and closing tasks
	// ----------------------------------------
	task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic checkDigest(input logic [255:0] got, input logic [255:0] exp);
		nCompared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic endSim();
		$display("compared %0d mismatches %0d", nCompared, mismatches);
		if (mismatches == 0 && nCompared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Bus monitor
	// ----------------------------------------
	always @(posedge clk) begin
		if (u_bhc_link_if.rdStb === 1'b1) begin
			checkVal(32'(u_bhc_link_if.addr), 32'(rdCnt));
			rdCnt++;
		end
		if (u_bhc_link_if.wrStb === 1'b1 && wrCnt < 16) begin
			checkVal(32'(u_bhc_link_if.addr), 32'(wrCnt));
			wrImage[255 - 16 * wrCnt -: 16] = u_bhc_link_if.wdata;
			wrCnt++;
		end
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic loadImage(input logic [255:0] st, input logic [511:0] blk);
		logic [767:0] img;
		img = {st, blk};
		for (int i = 0; i < 48; i++) begin
			@(posedge clk);
			loadEn   <= 1'b1;
			loadAddr <= 6'(i);
			loadData <= img[767 - 16 * i -: 16];
		end
		@(posedge clk);
		loadEn <= 1'b0;
	endtask

	// Optional poke retries start and a load while busy; both must be ignored
	task automatic runBlock(input logic mode, input logic chk,
		input logic [255:0] exp, input logic poke);
		int n;
		rdCnt = 0;
		wrCnt = 0;
		@(posedge clk);
		start   <= 1'b1;
		intMode <= mode;
		@(posedge clk);
		start <= 1'b0;
		if (poke) begin
			repeat (6) @(posedge clk);
			checkVal(32'(busy), 32'h1);
			start    <= 1'b1;
			loadEn   <= 1'b1;
			loadAddr <= 6'h00;
			loadData <= 16'hFFFF;
			@(posedge clk);
			start  <= 1'b0;
			loadEn <= 1'b0;
		end
		n = 0;
		while (digestValid !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n == 2000) begin
			mismatches++;
			endSim();
		end
		if (chk)
			checkDigest(digest, exp);
		repeat (10) @(posedge clk);
		checkDigest(wrImage, digest);
		checkVal(32'(rdCnt), 32'h30);
		checkVal(32'(wrCnt), 32'h10);
		checkVal(32'(busy), 32'h0);
		$display("test done: mode %0b at %0t", mode, $time);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst        = 1'b1;
		loadEn     = 1'b0;
		loadAddr   = 6'h00;
		loadData   = 16'h0000;
		start      = 1'b0;
		intMode    = 1'b0;
		mismatches = 0;
		nCompared  = 0;
		rdCnt      = 0;
		wrCnt      = 0;
		wrImage    = 256'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		loadImage(ivStd, blkAbc);
		runBlock(1'b0, 1'b1, digAbc, 1'b1);
		loadImage(ivStd, blkAbc);
		runBlock(1'b1, 1'b1, digAbc, 1'b0);
		loadImage(ivStd, blkOne);
		runBlock(1'b1, 1'b0, digAbc, 1'b0);
		loadImage(digest, blkTwo);
		runBlock(1'b0, 1'b1, digTwo, 1'b0);
		endSim();
	end
endmodule
`default_nettype wire
